/* File: ridc_regs.sv */
// module: reference input demodulator configuration bank and event sequencing
//
// Our own choice: strobed register access.
`timescale 1ns/1ns

// Overview of operation
// R1: bit 3 enables a-complement demodulator, resets 0
// R2: bit 2 picks narrow-first or wide-first event
// R3: bits 1:0 sensitivity, 00 most sensitive
// R4: bits 7:6 b-complement single-ended mode
// R5: bits 5:4 b-true single-ended mode, reset 0
// R6: b demod settings layout, both reset 0x40
// R7: persist gives continuous events after five events
// R8: sync edge field delays output by edges
// R9: bit 7 auto polarity, else programmed polarity
// R10: reserved bits read zero, ignore writes
module ridc_regs
  import ridc_pkg::*;
#(
  parameter int PERSIST_N = PERSIST_EVENTS
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rdata,
  // demodulator path events, one bit per channel
  input  wire logic [NCH-1:0]    evt_det,
  input  wire logic [NCH-1:0]    evt_break,
  input  wire logic [NCH-1:0]    base_edge,
  input  wire logic [NCH-1:0]    sync_edge,
  input  wire logic [NCH-1:0]    auto_pol,
  // per-channel controls and results
  output logic      [NCH-1:0]    demod_en,
  output logic      [2*NCH-1:0]  demod_sens,
  output logic      [NCH-1:0]    pol_eff,
  output logic      [NCH-1:0]    persist_on,
  output logic      [NCH-1:0]    demod_out,
  // receiver controls
  output logic      [1:0]        se_mode_comp,
  output logic      [1:0]        se_mode_true,
  output logic      [1:0]        diff_mode,
  output logic                   in_mode_diff,
  output logic                   band_high
);

  // the counter is three bits wide, so PERSIST_N can be at most seven events
  if (PERSIST_N < 1 || PERSIST_N > 7) begin : g_chk
    $error("PERSIST_N must lie in 1..7");
  end

  localparam logic [2:0] PN = 3'(PERSIST_N);
  localparam logic [ADDR_W-1:0] A_A_DEMOD = {IDX_A_DEMOD, 2'b00};
  localparam logic [ADDR_W-1:0] A_RX      = {IDX_RX, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAND    = {IDX_BAND, 2'b00};
  localparam logic [ADDR_W-1:0] A_B_TRUE  = {IDX_B_TRUE, 2'b00};
  localparam logic [ADDR_W-1:0] A_B_COMP  = {IDX_B_COMP, 2'b00};
  localparam logic [ADDR_W-1:0] A_STATUS  = {IDX_STATUS, 2'b00};

  logic [7:0]     demod_q [NCH];
  logic [7:0]     rx_q;
  logic [7:0]     band_q;
  logic [7:0]     rdata_q;
  logic [2:0]     cnt_q   [NCH];
  logic [2:0]     cnt_d   [NCH];
  logic [1:0]     left_q  [NCH];
  logic [1:0]     left_d  [NCH];
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] pend_d;
  logic [NCH-1:0] out_q;
  logic [NCH-1:0] fire_d;
  logic [NCH-1:0] pol_q;
  logic [NCH-1:0] pol_d;
  logic [NCH-1:0] start;
  logic [NCH-1:0] pers;
  logic [NCH-1:0] we_demod;

  // address decode; strobes only count while the block is clocked
  wire we      = wr_stb & ce;
  wire re      = rd_stb & ce;
  wire we_rx   = we & (addr == A_RX);
  wire we_band = we & (addr == A_BAND);
  assign we_demod[CH_A_COMP] = we & (addr == A_A_DEMOD);
  assign we_demod[CH_B_TRUE] = we & (addr == A_B_TRUE);
  assign we_demod[CH_B_COMP] = we & (addr == A_B_COMP);

  // status shows live persist and pending-delay state
  wire [7:0] status = {2'b00, pend_q, persist_on};

  // read select; unmapped addresses read zero
  wire [7:0] rd_mux =
    (addr == A_A_DEMOD) ? demod_q[CH_A_COMP] :
    (addr == A_RX)      ? rx_q :
    (addr == A_BAND)    ? band_q :
    (addr == A_B_TRUE)  ? demod_q[CH_B_TRUE] :
    (addr == A_B_COMP)  ? demod_q[CH_B_COMP] :
    (addr == A_STATUS)  ? status : 8'h00;

  // per-channel sequencing: enable, persist count, sync-edge delay, polarity
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [7:0] cfg = demod_q[c];
    wire       en  = cfg[F_EN];                            // [R1]
    wire [1:0] sn  = cfg[F_SYNC_HI:F_SYNC_LO];
    assign pers[c]  = cfg[F_PERSIST] & (cnt_q[c] >= PN);   // [R7]
    // a base edge alone restarts output only once persist is running
    assign start[c] = en & (evt_det[c] | (pers[c] & base_edge[c])); // [R7]
    assign cnt_d[c] = (!en || evt_break[c]) ? 3'h0 :
                      (evt_det[c] && cnt_q[c] < PN) ? cnt_q[c] + 3'h1 : cnt_q[c];
    // a new start (an event, or a base edge once persist is running) while waiting restarts the delay from its own edge
    // en gates the pending path too, so disabling drops a half-done delay
    assign fire_d[c] = start[c] ? (sn == 2'h0) :
                       (en & pend_q[c] & sync_edge[c] & (left_q[c] == 2'h1)); // [R1] [R8]
    assign pend_d[c] = !en ? 1'b0 : start[c] ? (sn != 2'h0) :
                       (pend_q[c] & sync_edge[c] & (left_q[c] == 2'h1)) ? 1'b0 : pend_q[c];
    assign left_d[c] = start[c] ? sn :
                       (pend_q[c] & sync_edge[c]) ? left_q[c] - 2'h1 : left_q[c]; // [R8]
    assign pol_d[c]  = cfg[F_AUTO_POL] ? auto_pol[c] : cfg[F_POL]; // [R2] [R9]
    assign demod_en[c] = en;
    assign demod_sens[2*c +: 2] = cfg[F_SENS_HI:F_SENS_LO];        // [R3]
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      demod_q[CH_A_COMP] <= RST_A_DEMOD;                   // [R1]
      demod_q[CH_B_TRUE] <= RST_B_DEMOD;                   // [R6]
      demod_q[CH_B_COMP] <= RST_B_DEMOD;                   // [R6]
      rx_q   <= RST_RX;                                    // [R5]
      band_q <= RST_BAND;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (we_demod[i]) begin
          demod_q[i] <= wdata;                             // [R6]
        end
      end
      if (we_rx) begin
        rx_q <= wdata & RX_WMASK;                          // [R4] [R5] [R10]
      end
      if (we_band) begin
        band_q <= wdata & BAND_WMASK;                      // [R10]
      end
    end
  end

  // sequencing state and read data, all frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      pend_q  <= '0;
      out_q   <= '0;
      pol_q   <= '0;
      for (int i = 0; i < NCH; i++) begin
        cnt_q[i]  <= 3'h0;
        left_q[i] <= 2'h0;
      end
    end else if (ce) begin
      rdata_q <= re ? rd_mux : 8'h00;
      pend_q  <= pend_d;
      out_q   <= fire_d;
      pol_q   <= pol_d;
      for (int i = 0; i < NCH; i++) begin
        cnt_q[i]  <= cnt_d[i];
        left_q[i] <= left_d[i];
      end
    end
  end

  // outputs; receiver modes feed the analog front end directly
  assign rdata        = rdata_q;
  assign demod_out    = out_q;
  assign pol_eff      = pol_q;
  assign persist_on   = pers;
  assign se_mode_comp = rx_q[F_RX_COMP_HI:F_RX_COMP_LO];   // [R4]
  assign se_mode_true = rx_q[F_RX_TRUE_HI:F_RX_TRUE_LO];   // [R5]
  assign diff_mode    = rx_q[F_RX_DIFF_HI:F_RX_DIFF_LO];
  assign in_mode_diff = rx_q[F_RX_INMODE];
  assign band_high    = band_q[F_BAND_SEL];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_b_true;
    wr_stb && ce && (addr == A_B_TRUE);
  endsequence

  sequence s_rd_b_true;
    rd_stb && ce && (addr == A_B_TRUE);
  endsequence

  a_reset_values: assert property ( // [R1] [R6]
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> demod_en == 3'h0 && demod_q[CH_B_TRUE] == 8'h40
                && demod_q[CH_B_COMP] == 8'h40 && se_mode_true == 2'h0)
    else $error("reset values wrong");

  a_a_enable: assert property ( // [R1]
    we_demod[CH_A_COMP] |=> demod_en[CH_A_COMP] == $past(wdata[3]))
    else $error("a-complement enable not written");

  a_fixed_polarity: assert property ( // [R2] [R9]
    ce && !demod_q[CH_A_COMP][F_AUTO_POL] |=> pol_eff[CH_A_COMP] == $past(demod_q[0][2]))
    else $error("programmed polarity not used");

  a_auto_polarity: assert property ( // [R9]
    ce && demod_q[CH_B_COMP][F_AUTO_POL] |=> pol_eff[CH_B_COMP] == $past(auto_pol[2]))
    else $error("auto polarity not followed");

  a_sens_write: assert property ( // [R3]
    we_demod[CH_A_COMP] |=> demod_sens[1:0] == $past(wdata[1:0]))
    else $error("sensitivity not written");

  a_rx_modes: assert property ( // [R4] [R5]
    we_rx |=> se_mode_comp == $past(wdata[7:6]) && se_mode_true == $past(wdata[5:4]))
    else $error("single-ended modes not written");

  a_b_readback: assert property ( // [R6]
    s_wr_b_true ##1 s_rd_b_true |=> rdata == $past(wdata, 2))
    else $error("b-true settings readback wrong");

  a_persist_gate: assert property ( // [R7]
    persist_on[CH_B_COMP] |-> demod_q[CH_B_COMP][F_PERSIST] && cnt_q[CH_B_COMP] >= PN)
    else $error("persist active too early");

  a_persist_build: assert property ( // [R7]
    ce && demod_q[2][F_EN] && demod_q[2][F_PERSIST] && !evt_break[2] && evt_det[2]
    && cnt_q[2] == PN - 3'h1 |=> persist_on[2] || !ce || !demod_q[2][F_PERSIST])
    else $error("persist not reached on final event");

  a_no_delay: assert property ( // [R8]
    ce && start[CH_B_TRUE] && demod_q[1][F_SYNC_HI:F_SYNC_LO] == 2'h0
    |=> demod_out[CH_B_TRUE])
    else $error("zero delay output missing");

  a_delay_one: assert property ( // [R8]
    ce && start[2] && demod_q[2][F_SYNC_HI:F_SYNC_LO] == 2'h1 |=> !demod_out[2])
    else $error("delayed output came too soon");

  a_rsvd_zero: assert property ( // [R10]
    re && (addr == A_RX || addr == A_BAND) |=> rdata[1] == 1'b0)
    else $error("reserved bit reads nonzero");

  a_band_rsvd: assert property ( // [R10]
    re && addr == A_BAND |=> rdata[7:1] == 7'h00)
    else $error("band reserved bits read nonzero");

  a_unmapped_zero: assert property ( // [R10]
    re && (addr < A_A_DEMOD || addr > A_STATUS)
    |=> rdata == 8'h00)
    else $error("unmapped address reads nonzero");

  a_rx_other: assert property ( // [R4]
    we_rx |=> diff_mode == $past(wdata[3:2]) && in_mode_diff == $past(wdata[0]))
    else $error("receiver mode fields not written");

  // register writes land in the next cycle
  a_b_comp_write: assert property ( // [R6]
    we_demod[CH_B_COMP] |=> demod_q[CH_B_COMP] == $past(wdata))
    else $error("b-comp settings not written");

  a_b_true_enable: assert property ( // [R6]
    we_demod[CH_B_TRUE] |=> demod_en[CH_B_TRUE] == $past(wdata[F_EN]))
    else $error("b-true enable not written");

  a_sens_b_comp: assert property ( // [R3]
    we_demod[CH_B_COMP] |=> demod_sens[5:4] == $past(wdata[1:0]))
    else $error("b-comp sensitivity not written");

  // persist count, break and enable gating; b-true programmed polarity
  a_persist_off: assert property ( // [R7]
    !demod_q[CH_B_COMP][F_PERSIST] |-> !persist_on[CH_B_COMP])
    else $error("persist active while disabled");

  a_break_clear: assert property ( // [R7]
    ce && evt_break[CH_B_COMP] |=> !persist_on[CH_B_COMP])
    else $error("break did not clear persist");

  a_disable_quiet: assert property ( // [R1]
    ce && !demod_en[CH_A_COMP] |=> !demod_out[CH_A_COMP])
    else $error("disabled demodulator produced output");

  a_pol_b_true: assert property ( // [R2] [R9]
    ce && !demod_q[CH_B_TRUE][F_AUTO_POL]
    |=> pol_eff[CH_B_TRUE] == $past(demod_q[CH_B_TRUE][F_POL]))
    else $error("b-true programmed polarity not used");

  // one-edge delay on b-comp: start, then a sync edge in the very next cycle
  sequence s_start_b_comp_d1;
    ce && start[CH_B_COMP] && demod_q[CH_B_COMP][F_SYNC_HI:F_SYNC_LO] == 2'h1;
  endsequence

  sequence s_sync_b_comp;
    ce && demod_en[CH_B_COMP] && sync_edge[CH_B_COMP] && !start[CH_B_COMP];
  endsequence

  a_sync_first: assert property ( // [R8]
    s_start_b_comp_d1 ##1 s_sync_b_comp |=> demod_out[CH_B_COMP])
    else $error("one-edge delayed output missing");

endmodule

/* File: ridc_pkg.sv */
// package: register indices, field positions, reset values and mode codes for the demod config bank
package ridc_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [11:0] IDX_A_DEMOD = 12'h303;
  localparam logic [11:0] IDX_RX      = 12'h304;
  localparam logic [11:0] IDX_BAND    = 12'h305;
  localparam logic [11:0] IDX_B_TRUE  = 12'h306;
  localparam logic [11:0] IDX_B_COMP  = 12'h307;
  localparam logic [11:0] IDX_STATUS  = 12'h308;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int NCH    = 3;

  // channel numbering: 0 = a-side complement, 1 = b-side true, 2 = b-side complement
  localparam int CH_A_COMP = 0;
  localparam int CH_B_TRUE = 1;
  localparam int CH_B_COMP = 2;

  // reset values
  localparam logic [7:0] RST_A_DEMOD = 8'h00;
  localparam logic [7:0] RST_RX      = 8'h00;
  localparam logic [7:0] RST_BAND    = 8'h01;
  localparam logic [7:0] RST_B_DEMOD = 8'h40;

  // writable-bit masks; reserved bits stay zero
  localparam logic [7:0] RX_WMASK   = 8'hFD;
  localparam logic [7:0] BAND_WMASK = 8'h01;

  // demod settings fields
  localparam int F_AUTO_POL = 7;
  localparam int F_PERSIST  = 6;
  localparam int F_SYNC_HI  = 5;
  localparam int F_SYNC_LO  = 4;
  localparam int F_EN       = 3;
  localparam int F_POL      = 2;
  localparam int F_SENS_HI  = 1;
  localparam int F_SENS_LO  = 0;

  // receiver settings fields
  localparam int F_RX_COMP_HI = 7;
  localparam int F_RX_COMP_LO = 6;
  localparam int F_RX_TRUE_HI = 5;
  localparam int F_RX_TRUE_LO = 4;
  localparam int F_RX_DIFF_HI = 3;
  localparam int F_RX_DIFF_LO = 2;
  localparam int F_RX_INMODE  = 0;
  localparam int F_BAND_SEL   = 0;

  // consecutive modulation events needed before persist output starts
  localparam int PERSIST_EVENTS = 5;

  // single-ended receiver modes
  typedef enum logic [1:0] {
    SE_AC_12   = 2'h0,
    SE_CMOS_12 = 2'h1,
    SE_CMOS_18 = 2'h2,
    SE_NO_PULL = 2'h3
  } ridc_se_mode_e;

endpackage

/* File: ridc_regs_tb.sv */
// testbench: register bank, field outputs and event sequencing of the demod config block
`timescale 1ns/1ns
module ridc_regs_tb;
  import ridc_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic              wr_stb;
  logic              rd_stb;
  logic [7:0]        rdata;
  logic [2:0]        evt_det;
  logic [2:0]        evt_break;
  logic [2:0]        base_edge;
  logic [2:0]        sync_edge;
  logic [2:0]        auto_pol;
  logic [2:0]        demod_en;
  logic [5:0]        demod_sens;
  logic [2:0]        pol_eff;
  logic [2:0]        persist_on;
  logic [2:0]        demod_out;
  logic [1:0]        se_mode_comp;
  logic [1:0]        se_mode_true;
  logic              band_high;
  logic [1:0]        diff_mode;
  logic              in_mode_diff;
  logic              ce;
  logic [7:0]        v;
  int                mismatches;
  int                num_checks;

  // ce is driven so the freeze path is exercised as well
  ridc_regs u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .evt_det(evt_det),
    .evt_break(evt_break), .base_edge(base_edge), .sync_edge(sync_edge),
    .auto_pol(auto_pol), .demod_en(demod_en), .demod_sens(demod_sens), .pol_eff(pol_eff),
    .persist_on(persist_on), .demod_out(demod_out), .se_mode_comp(se_mode_comp),
    .se_mode_true(se_mode_true), .diff_mode(diff_mode), .in_mode_diff(in_mode_diff),
    .band_high(band_high));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // bus cycles; outputs are looked at 1 ns after the edge so register updates have landed
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] idx, output logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // one cycle of demodulator path inputs
  task automatic step(input logic [2:0] d, input logic [2:0] k, input logic [2:0] b,
                      input logic [2:0] s);
    @(posedge clk);
    evt_det <= d;
    evt_break <= k;
    base_edge <= b;
    sync_edge <= s;
    #1;
  endtask

  task automatic t_reset;
    logic [11:0] ix [5] = '{IDX_A_DEMOD, IDX_RX, IDX_BAND, IDX_B_TRUE, IDX_B_COMP};
    logic [7:0]  ex [5] = '{8'h00, 8'h00, 8'h01, 8'h40, 8'h40};
    for (int i = 0; i < 5; i++) begin
      rd(ix[i], v);
      chk("reset value", ex[i], v);
    end
    wr(12'h309, 8'hFF);
    rd(12'h309, v);
    chk("unmapped", 8'h00, v);
  endtask

  // every single-ended mode code on both fields, reserved bits forced high
  task automatic t_rx;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_RX, {i[1:0], ~i[1:0], i[1:0], 1'b1, i[0]});
      rd(IDX_RX, v);
      chk("rx readback", {i[1:0], ~i[1:0], i[1:0], 1'b0, i[0]}, v);
      chk("diff mode", {6'h00, i[1:0]}, {6'h00, diff_mode});
      chk("input mode", {7'h00, i[0]}, {7'h00, in_mode_diff});
      chk("se comp", {6'h00, i[1:0]}, {6'h00, se_mode_comp});
      chk("se true", {6'h00, ~i[1:0]}, {6'h00, se_mode_true});
    end
    wr(IDX_BAND, 8'hFE);
    rd(IDX_BAND, v);
    chk("band readback", 8'h00, v);
    chk("band high", 8'h00, {7'h00, band_high});
  endtask

  task automatic t_acomp;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_A_DEMOD, {5'h01, i[0], i[1:0]});
      step(3'h0, 3'h0, 3'h0, 3'h0);
      chk("a enable", 8'h01, {7'h00, demod_en[0]});
      chk("a sens", {6'h00, i[1:0]}, {6'h00, demod_sens[1:0]});
      chk("a pol", {7'h00, i[0]}, {7'h00, pol_eff[0]});
    end
  endtask

  // a-side enable gates events; b-true with two sync edges of delay
  task automatic t_event;
    wr(IDX_A_DEMOD, 8'h00);
    step(3'h1, 3'h0, 3'h0, 3'h0);
    step(3'h0, 3'h0, 3'h0, 3'h0);
    chk("a off out", 8'h00, {7'h00, demod_out[0]});
    wr(IDX_A_DEMOD, 8'h08);
    step(3'h1, 3'h0, 3'h0, 3'h0);
    step(3'h0, 3'h0, 3'h0, 3'h0);
    chk("a on out", 8'h01, {7'h00, demod_out[0]});
    wr(IDX_B_TRUE, 8'h08);
    step(3'h2, 3'h0, 3'h0, 3'h0);
    step(3'h0, 3'h0, 3'h0, 3'h0);
    chk("b zero delay", 8'h01, {7'h00, demod_out[1]});
    wr(IDX_B_TRUE, 8'h28);
    for (int i = 0; i < 9; i++) begin
      step((i == 0) ? 3'h2 : 3'h0, 3'h0, 3'h0, (i == 3 || i == 5) ? 3'h2 : 3'h0);
      chk("sync delay", {7'h00, i == 6}, {7'h00, demod_out[1]});
    end
    // one sync edge of delay; the edge beside the event itself is not counted
    wr(IDX_B_COMP, 8'h18);
    for (int i = 0; i < 5; i++) begin
      step((i == 0) ? 3'h4 : 3'h0, 3'h0, 3'h0, (i < 2) ? 3'h4 : 3'h0);
      chk("sync one", {7'h00, i == 2}, {7'h00, demod_out[2]});
    end
  endtask

  task automatic t_persist;
    for (int p = 1; p >= 0; p--) begin
      wr(IDX_B_COMP, {1'b0, p[0], 6'h08});
      step(3'h0, 3'h4, 3'h0, 3'h0);
      for (int i = 0; i < 6; i++) begin
        step((i < 5) ? 3'h4 : 3'h0, 3'h0, 3'h0, 3'h0);
        chk("persist on", {7'h00, p[0] && i == 5}, {7'h00, persist_on[2]});
      end
      step(3'h0, 3'h0, 3'h4, 3'h0);
      step(3'h0, 3'h0, 3'h0, 3'h0);
      chk("persist event", {7'h00, p[0]}, {7'h00, demod_out[2]});
    end
    wr(IDX_B_COMP, 8'h48);
    step(3'h0, 3'h4, 3'h0, 3'h0);
    step(3'h0, 3'h0, 3'h0, 3'h0);
    chk("break clears", 8'h00, {7'h00, persist_on[2]});
  endtask

  task automatic t_autopol;
    @(posedge clk);
    auto_pol <= 3'h6;
    wr(IDX_B_TRUE, 8'h80);
    wr(IDX_B_COMP, 8'h80);
    step(3'h0, 3'h0, 3'h0, 3'h0);
    chk("auto pol b", 8'h01, {7'h00, pol_eff[1]});
    chk("auto pol bb", 8'h01, {7'h00, pol_eff[2]});
    @(posedge clk);
    auto_pol <= 3'h0;
    wr(IDX_B_TRUE, 8'h04);
    step(3'h0, 3'h0, 3'h0, 3'h0);
    chk("fixed pol", 8'h01, {7'h00, pol_eff[1]});
    chk("auto pol follow", 8'h00, {7'h00, pol_eff[2]});
  endtask

  // write then read with no gap between the strobes
  task automatic t_b2b;
    @(posedge clk);
    addr <= {IDX_B_TRUE, 2'b00};
    wdata <= 8'h35;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
    chk("b2b readback", 8'h35, v);
  endtask

  // a write while ce is low is ignored
  task automatic t_freeze;
    wr(IDX_B_COMP, 8'h2A);
    @(posedge clk);
    ce <= 1'b0;
    wr(IDX_B_COMP, 8'h15);
    @(posedge clk);
    ce <= 1'b1;
    rd(IDX_B_COMP, v);
    chk("frozen write", 8'h2A, v);
  endtask

  // reset in mid-run brings written registers back to their reset values
  task automatic t_midrst;
    wr(IDX_A_DEMOD, 8'hFF);
    wr(IDX_RX, 8'hFF);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(IDX_A_DEMOD, v);
    chk("a after reset", 8'h00, v);
    rd(IDX_RX, v);
    chk("rx after reset", 8'h00, v);
    chk("pol after reset", 8'h00, {5'h00, pol_eff});
  endtask

  // watchdog, well beyond the roughly 140 cycles the run needs
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end

  initial begin
    {sys_rst, addr, wdata, wr_stb, rd_stb} = '0;
    {evt_det, evt_break, base_edge, sync_edge, auto_pol} = '0;
    ce = 1'b1;
    mismatches = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_b2b();
    t_rx();
    t_acomp();
    t_event();
    t_persist();
    t_autopol();
    t_freeze();
    t_midrst();
    close_out();
  end
endmodule
